// ---- rtl/umps_core.sv ----
// The placing of the registers and the AXI4-Lite register port were decided locally.
`default_nettype none
module umps_core
    import umps_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [umps_pkg::AW-1:0]  awaddr,
    input  wire logic [2:0]               awprot,
    input  wire logic                     wvalid,
    output logic                          wready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    output logic                          bvalid,
    input  wire logic                     bready,
    output logic [1:0]                    bresp,
    input  wire logic                     arvalid,
    output logic                          arready,
    input  wire logic [umps_pkg::AW-1:0]  araddr,
    input  wire logic [2:0]               arprot,
    output logic                          rvalid,
    input  wire logic                     rready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    input  wire logic                     rx_done,
    input  wire logic [8:0]               rx_bits,
    input  wire logic                     rx_noise,
    input  wire logic                     rx_framing,
    input  wire logic                     rx_idle_frame,
    input  wire logic                     rx_busy,
    input  wire logic                     tx_idle,
    input  wire logic                     tx_frame_done,
    input  wire logic                     tx_frame_data,
    input  wire logic                     irq_global_mask,
    input  wire logic                     halt_mode,
    input  wire logic                     wait_mode,
    output logic                          tx_load,
    output logic [8:0]                    tx_word,
    output logic                          tx_len_nine,
    output logic                          tx_parity_en,
    output logic                          tx_parity_odd,
    output logic                          tx_enable,
    output logic                          rx_enable,
    output logic                          send_break,
    output logic                          serial_run,
    output logic                          irq,
    output logic                          wait_wake
);
    import umps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       awready;
        logic       wready;
        logic       arready;
        logic       aw_got;
        logic [2:0] aw_sel;
        logic       w_got;
        logic [7:0] wdat;
        logic       wen;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] st;
        logic [7:0] arm;
        logic [6:0] cr1;
        logic       rx9;
        logic [7:0] cr2;
        logic [7:0] tx_hold;
        logic       tx_pend;
        logic [7:0] rx_hold;
        logic       idle_lock;
        logic       rx_len9;
        logic       rx_pce;
        logic       rx_ps;
        logic       tx_load;
        logic [8:0] tx_word;
        logic       tx_len9;
        logic       tx_pce;
        logic       tx_ps;
        logic       run;
        logic       irq;
        logic       wake;
    } umps_state_s;

    umps_state_s s;
    umps_state_s next_s;

    // Decoding shared by the read and write paths
    function automatic logic [2:0] umps_sel(input logic [AW-1:0] a);
        case (a)
            OFF_STATUS: umps_sel = SEL_STATUS;
            OFF_CTRL1:  umps_sel = SEL_CTRL1;
            OFF_CTRL2:  umps_sel = SEL_CTRL2;
            OFF_DATA:   umps_sel = SEL_DATA;
            default:    umps_sel = SEL_NONE;
        endcase
    endfunction : umps_sel

    // Parity of the low data bits; even parity bit equals this value
    function automatic logic umps_par(input logic [8:0] d, input logic len9);
        umps_par = len9 ? ^d[7:0] : ^d[6:0];
    endfunction : umps_par

    ////////////////////////////////////////////////////////////////////////////
    logic       do_wr;
    logic       do_rd;
    logic [2:0] rsel;
    logic       st_acc;
    logic       dr_rd;
    logic       dr_wr;
    logic       muted;
    logic       addr_mark;
    logic       deliver;
    logic       par_bad;
    logic [8:0] word;

    always_comb begin
        next_s = s;
        rsel = umps_sel(araddr);
        do_wr = s.aw_got && s.w_got && !s.bvalid;
        do_rd = arvalid && s.arready;
        st_acc = (do_rd && rsel == SEL_STATUS) || (do_wr && s.aw_sel == SEL_STATUS);
        dr_rd = do_rd && rsel == SEL_DATA;
        dr_wr = do_wr && s.aw_sel == SEL_DATA && s.wen;
        muted = s.cr2[C2_MUTE];
        // Top data bit, skipping the parity position when parity is on
        case ({s.rx_len9, s.rx_pce})
            2'b00:   addr_mark = rx_bits[7];
            2'b01:   addr_mark = rx_bits[6];
            2'b10:   addr_mark = rx_bits[8];
            default: addr_mark = rx_bits[7];
        endcase
        deliver = !muted || (s.cr1[C1_WAKE] && addr_mark);
        par_bad = s.rx_pce && (umps_par(rx_bits, s.rx_len9)
                  ^ (s.rx_len9 ? rx_bits[8] : rx_bits[7]) ^ s.rx_ps);
        word = {s.cr1[C1_TX9], s.tx_hold};
        if (s.cr1[C1_PCE]) begin
            if (s.cr1[C1_LEN9]) begin
                word[8] = umps_par(word, 1'b1) ^ s.cr1[C1_PS];
            end else begin
                word[7] = umps_par(word, 1'b0) ^ s.cr1[C1_PS];
            end
        end

        // AXI channel capture
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_sel = umps_sel(awaddr);
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdat = wdata[7:0];
            next_s.wen = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (do_wr) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = (s.aw_sel == SEL_NONE) ? RESP_SLV : RESP_OK;
        end
        if (do_rd) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = (rsel == SEL_NONE) ? RESP_SLV : RESP_OK;
            case (rsel)
                SEL_STATUS: next_s.rdata = s.st;
                SEL_CTRL1:  next_s.rdata = {s.rx9, s.cr1};
                SEL_CTRL2:  next_s.rdata = s.cr2;
                SEL_DATA:   next_s.rdata = s.rx_hold;
                default:    next_s.rdata = 8'h00;
            endcase
        end

        // Two-step clears first, so that hardware sets below win
        for (int b = 0; b < 8; b++) begin
            if ((b >= ST_TXD && dr_wr) || (b < ST_TXD && dr_rd)) begin
                if (s.arm[b]) begin
                    next_s.st[b] = 1'b0;
                    next_s.arm[b] = 1'b0;
                end
            end
            if (st_acc && s.st[b]) begin
                next_s.arm[b] = 1'b1;
            end
        end

        // Receive config follows the control bits only between bytes
        if (!rx_busy) begin
            next_s.rx_len9 = s.cr1[C1_LEN9];
            next_s.rx_pce = s.cr1[C1_PCE];
            next_s.rx_ps = s.cr1[C1_PS];
        end

        if (s.run && rx_done && deliver) begin
            if (muted) begin
                next_s.cr2[C2_MUTE] = 1'b0;
            end
            if (s.st[ST_RXF]) begin
                next_s.st[ST_OVR] = 1'b1;
            end else begin
                next_s.rx_hold = rx_bits[7:0];
                next_s.rx9 = s.rx_len9 ? rx_bits[8] : s.rx9;
                next_s.st[ST_RXF] = 1'b1;
                next_s.st[ST_NOISE] = rx_noise;
                next_s.st[ST_FRAME] = rx_framing;
                next_s.st[ST_PAR] = par_bad;
                next_s.idle_lock = 1'b0;
            end
        end
        if (s.run && rx_idle_frame) begin
            if (muted) begin
                if (!s.cr1[C1_WAKE]) begin
                    next_s.cr2[C2_MUTE] = 1'b0;
                end
            end else if (!s.idle_lock) begin
                next_s.st[ST_IDLE] = 1'b1;
                next_s.idle_lock = 1'b1;
            end
        end
        if (s.run && tx_frame_done && tx_frame_data) begin
            next_s.st[ST_TXD] = 1'b1;
        end

        // Holding register moves only once the empty flag was cleared
        next_s.tx_load = 1'b0;
        if (s.run && s.tx_pend && !s.st[ST_TXE] && tx_idle && !s.tx_load) begin
            next_s.tx_load = 1'b1;
            next_s.tx_pend = 1'b0;
            next_s.st[ST_TXE] = 1'b1;
            next_s.tx_word = word;
            next_s.tx_len9 = s.cr1[C1_LEN9];
            next_s.tx_pce = s.cr1[C1_PCE];
            next_s.tx_ps = s.cr1[C1_PS];
        end

        // Register writes; a control two write overrides a wake in the same cycle
        if (do_wr && s.wen) begin
            case (s.aw_sel)
                SEL_CTRL1: next_s.cr1 = s.wdat[6:0];
                SEL_CTRL2: next_s.cr2 = s.wdat;
                SEL_DATA: begin
                    next_s.tx_hold = s.wdat;
                    next_s.tx_pend = 1'b1;
                end
                default: next_s.tx_pend = next_s.tx_pend;
            endcase
        end

        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        // Power-down waits for both shifters to go quiet
        next_s.run = !halt_mode && !(s.cr1[C1_PDOWN] && !rx_busy && tx_idle);
        next_s.irq = !irq_global_mask && (
              (next_s.st[ST_TXE] && next_s.cr2[C2_TXEIE])
            || (next_s.st[ST_TXD] && next_s.cr2[C2_TXDIE])
            || (!next_s.cr2[C2_MUTE] && (
                   ((next_s.st[ST_RXF] || next_s.st[ST_OVR]) && next_s.cr2[C2_RXIE])
                || (next_s.st[ST_IDLE] && next_s.cr2[C2_IDLEIE])
                || (next_s.st[ST_PAR] && next_s.cr1[C1_PIE]))));
        next_s.wake = next_s.irq && wait_mode && !halt_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.st <= ST_RESET;
            s.cr1 <= C1_RESET;
            s.cr2 <= C2_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign arready = s.arready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = {24'h000000, s.rdata};
    assign rresp = s.rresp;
    assign tx_load = s.tx_load;
    assign tx_word = s.tx_word;
    assign tx_len_nine = s.tx_len9;
    assign tx_parity_en = s.tx_pce;
    assign tx_parity_odd = s.tx_ps;
    assign tx_enable = s.cr2[C2_TE];
    assign rx_enable = s.cr2[C2_RE];
    assign send_break = s.cr2[C2_BRK];
    assign serial_run = s.run;
    assign irq = s.irq;
    assign wait_wake = s.wake;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_status_reset;
        $past(!aresetn) |-> s.st == 8'hC0;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status reset value wrong");

    sequence q_muted_word;
        s.run && rx_done && muted && !(s.cr1[C1_WAKE] && addr_mark);
    endsequence
    property p_mute_quiet;
        q_muted_word |=> !$rose(s.st[ST_RXF]) && !$rose(s.st[ST_OVR]);
    endproperty
    a_mute_quiet: assert property (p_mute_quiet) else $error("flag set while muted");

    property p_idle_wake;
        s.run && rx_idle_frame && muted && !s.cr1[C1_WAKE] && !do_wr
            |=> !s.cr2[C2_MUTE] && !$rose(s.st[ST_IDLE]);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

    property p_mark_wake;
        s.run && rx_done && muted && s.cr1[C1_WAKE] && addr_mark && !s.st[ST_RXF] && !do_wr
            |=> !s.cr2[C2_MUTE] && s.st[ST_RXF];
    endproperty
    a_mark_wake: assert property (p_mark_wake) else $error("address wake wrong");

    property p_overrun;
        s.run && rx_done && deliver && s.st[ST_RXF]
            |=> s.st[ST_OVR] && $stable(s.rx_hold) && !$rose(s.st[ST_FRAME]);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun handling wrong");

    property p_idle_once;
        s.idle_lock |=> !$rose(s.st[ST_IDLE]);
    endproperty
    a_idle_once: assert property (p_idle_once) else $error("idle set twice");

    property p_load_gate;
        $rose(s.tx_load) |-> $past(!s.st[ST_TXE]) && s.st[ST_TXE];
    endproperty
    a_load_gate: assert property (p_load_gate) else $error("holding moved early");

    property p_tx_parity;
        s.tx_load && s.tx_pce
            |-> ((s.tx_len9 ? ^s.tx_word[8:0] : ^s.tx_word[7:0]) == s.tx_ps);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("tx parity wrong");

    property p_irq_mask;
        s.irq |-> $past(!irq_global_mask) && (s.st != 8'h00);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq despite mask");
endmodule : umps_core
`default_nettype wire

// ---- include/umps_pkg.sv ----
`default_nettype none
package umps_pkg;
    localparam int          AW         = 6;
    // Register byte offsets
    localparam logic [5:0]  OFF_STATUS = 6'h00;
    localparam logic [5:0]  OFF_CTRL1  = 6'h04;
    localparam logic [5:0]  OFF_CTRL2  = 6'h08;
    localparam logic [5:0]  OFF_DATA   = 6'h0C;
    localparam logic [2:0]  SEL_STATUS = 3'h0;
    localparam logic [2:0]  SEL_CTRL1  = 3'h1;
    localparam logic [2:0]  SEL_CTRL2  = 3'h2;
    localparam logic [2:0]  SEL_DATA   = 3'h3;
    localparam logic [2:0]  SEL_NONE   = 3'h4;
    // Status bits
    localparam int          ST_TXE     = 7;
    localparam int          ST_TXD     = 6;
    localparam int          ST_RXF     = 5;
    localparam int          ST_IDLE    = 4;
    localparam int          ST_OVR     = 3;
    localparam int          ST_NOISE   = 2;
    localparam int          ST_FRAME   = 1;
    localparam int          ST_PAR     = 0;
    localparam logic [7:0]  ST_RESET   = 8'hC0;
    // Control one bits
    localparam int          C1_RX9     = 7;
    localparam int          C1_TX9     = 6;
    localparam int          C1_PDOWN   = 5;
    localparam int          C1_LEN9    = 4;
    localparam int          C1_WAKE    = 3;
    localparam int          C1_PCE     = 2;
    localparam int          C1_PS      = 1;
    localparam int          C1_PIE     = 0;
    localparam logic [6:0]  C1_RESET   = 7'h00;
    // Control two bits
    localparam int          C2_TXEIE   = 7;
    localparam int          C2_TXDIE   = 6;
    localparam int          C2_RXIE    = 5;
    localparam int          C2_IDLEIE  = 4;
    localparam int          C2_TE      = 3;
    localparam int          C2_RE      = 2;
    localparam int          C2_MUTE    = 1;
    localparam int          C2_BRK     = 0;
    localparam logic [7:0]  C2_RESET   = 8'h00;
    localparam logic [1:0]  RESP_OK    = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage : umps_pkg
`default_nettype wire

// ---- tb/umps_link_model.sv ----
`default_nettype none
module umps_link_model (
    input  wire logic       aclk,
    input  wire logic       tx_load,
    input  wire logic [8:0] tx_word,
    output logic            tx_idle       = 1'b1,
    output logic            tx_frame_done = 1'b0,
    output logic            tx_frame_data = 1'b0,
    output logic            rx_done       = 1'b0,
    output logic [8:0]      rx_bits       = 9'h000,
    output logic            rx_noise      = 1'b0,
    output logic            rx_framing    = 1'b0,
    output logic            rx_idle_frame = 1'b0,
    output logic            rx_busy       = 1'b0
);
    logic [8:0] last_word = 9'h000;
    logic [3:0] busy_cnt  = 4'h0;
    int         frames    = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Shifter takes the word, stays busy for a whole frame, then reports a data frame
    always @(posedge aclk) begin
        tx_frame_done <= 1'b0;
        if (tx_load) begin
            last_word <= tx_word;
            tx_idle <= 1'b0;
            busy_cnt <= 4'h6;
        end else if (busy_cnt == 4'h1) begin
            tx_idle <= 1'b1;
            tx_frame_done <= 1'b1;
            tx_frame_data <= 1'b1;
            frames <= frames + 1;
            busy_cnt <= 4'h0;
        end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bits are valid only with the done pulse; inverted afterwards so stale data shows
    task automatic deliver(input logic [8:0] b, input logic n, input logic f);
        @(posedge aclk);
        rx_busy <= 1'b1;
        repeat (3) @(posedge aclk);
        rx_bits <= b;
        rx_noise <= n;
        rx_framing <= f;
        rx_done <= 1'b1;
        rx_busy <= 1'b0;
        @(posedge aclk);
        rx_done <= 1'b0;
        rx_bits <= ~b;
    endtask : deliver
    task automatic idle;
        @(posedge aclk);
        rx_idle_frame <= 1'b1;
        @(posedge aclk);
        rx_idle_frame <= 1'b0;
    endtask : idle
endmodule : umps_link_model
`default_nettype wire

// ---- tb/umps_core_bench.sv ----
`default_nettype none
module umps_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import umps_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, irq_global_mask = 1'b0;
    logic halt_mode = 1'b0, wait_mode = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, tx_load, tx_len_nine, tx_parity_en;
    logic tx_parity_odd, tx_enable, rx_enable, send_break, serial_run, irq, wait_wake;
    logic tx_idle, tx_frame_done, tx_frame_data, rx_done, rx_noise, rx_framing;
    logic rx_idle_frame, rx_busy;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [8:0] rx_bits, tx_word;
    logic [7:0] rd_val;
    int n_mismatch = 0, check_count = 0, cycles = 0;
    umps_core DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
        .rvalid, .rready, .rdata, .rresp, .rx_done, .rx_bits, .rx_noise, .rx_framing,
        .rx_idle_frame, .rx_busy, .tx_idle, .tx_frame_done, .tx_frame_data,
        .irq_global_mask, .halt_mode, .wait_mode, .tx_load, .tx_word, .tx_len_nine,
        .tx_parity_en, .tx_parity_odd, .tx_enable, .rx_enable, .send_break, .serial_run,
        .irq, .wait_wake);
    umps_link_model link (.aclk, .tx_load, .tx_word, .tx_idle, .tx_frame_done,
        .tx_frame_data, .rx_done, .rx_bits, .rx_noise, .rx_framing, .rx_idle_frame,
        .rx_busy);
    always #10 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready && awvalid)
                awvalid <= 1'b0;
            if (wready && wvalid)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready && arvalid)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rd_val = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e,
                        input logic [7:0] m);
        rd(a);
        chk(nm, {1'b0, e & m}, {1'b0, rd_val & m});
    endtask : rchk
    // Status access arms the flags, the data read then clears the receive flags among them
    task automatic clear_rx;
        rd(OFF_STATUS);
        rd(OFF_DATA);
    endtask : clear_rx
    task automatic tx_one(input logic [7:0] c1, input logic [7:0] d, input logic [8:0] ew,
                          input logic [8:0] m, input logic [2:0] cfg);
        int f;
        f = link.frames;
        wr(OFF_CTRL1, c1);
        rd(OFF_STATUS);
        wr(OFF_DATA, d);
        wait (link.frames == f + 1);
        chk("tx_word", ew & m, link.last_word & m);
        chk("tx_cfg", {6'h00, cfg}, {6'h00, tx_len_nine, tx_parity_en, tx_parity_odd});
        rchk("status", OFF_STATUS, 8'hC0, 8'hC0);
    endtask : tx_one
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("status", OFF_STATUS, ST_RESET, 8'hFF);
        rchk("ctrl1", OFF_CTRL1, 8'h00, 8'hFF);
        wr(OFF_STATUS, 8'h00);
        rchk("status", OFF_STATUS, ST_RESET, 8'hFF);
        wr(6'h10, 8'hFF);
        chk("wresp", {7'h00, RESP_SLV}, {7'h00, resp});
        rd(6'h10);
        chk("rresp", {7'h00, RESP_SLV}, {7'h00, resp});
        wr(OFF_CTRL2, 8'h0C);
        chk("ctl_out", 9'h006, {6'h00, tx_enable, rx_enable, send_break});
        tx_one(8'h50, 8'h12, 9'h112, 9'h1FF, 3'b100);
        // Odd parity over 0110101 (four ones) puts a 1 in bit 7
        tx_one(8'h06, 8'h35, 9'h0B5, 9'h0FF, 3'b011);
        // Receive, parity even, receive interrupt enabled
        wr(OFF_CTRL1, 8'h04);
        wr(OFF_CTRL2, 8'h24);
        link.deliver(9'h035, 1'b1, 1'b0);
        rchk("status", OFF_STATUS, 8'h24, 8'h3F);
        wait_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("irq", 9'h001, {8'h00, irq});
        chk("wake", 9'h001, {8'h00, wait_wake});
        irq_global_mask <= 1'b1;
        wait_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("irq", 9'h000, {8'h00, irq});
        irq_global_mask <= 1'b0;
        rchk("data", OFF_DATA, 8'h35, 8'hFF);
        rchk("status", OFF_STATUS, 8'h00, 8'h3F);
        link.deliver(9'h0B5, 1'b0, 1'b0);
        rchk("status", OFF_STATUS, 8'h21, 8'h3F);
        clear_rx();
        wr(OFF_CTRL1, 8'h06);
        link.deliver(9'h0B5, 1'b0, 1'b0);
        link.deliver(9'h013, 1'b0, 1'b1);
        rchk("status", OFF_STATUS, 8'h28, 8'h3F);
        rchk("data", OFF_DATA, 8'hB5, 8'hFF);
        wr(OFF_CTRL1, 8'h10);
        link.deliver(9'h1AA, 1'b0, 1'b0);
        rchk("ctrl1", OFF_CTRL1, 8'h80, 8'h80);
        clear_rx();
        // Mute is only set here from a known state, never rewritten while muted
        wr(OFF_CTRL1, 8'h08);
        wr(OFF_CTRL2, 8'h26);
        link.deliver(9'h011, 1'b0, 1'b0);
        rchk("status", OFF_STATUS, 8'h00, 8'h3F);
        chk("irq", 9'h000, {8'h00, irq});
        link.deliver(9'h081, 1'b0, 1'b0);
        rchk("ctrl2", OFF_CTRL2, 8'h24, 8'hFF);
        rchk("status", OFF_STATUS, 8'h20, 8'h3F);
        rchk("data", OFF_DATA, 8'h81, 8'hFF);
        wr(OFF_CTRL1, 8'h0C);
        wr(OFF_CTRL2, 8'h26);
        link.deliver(9'h080, 1'b0, 1'b0);
        rchk("ctrl2", OFF_CTRL2, 8'h26, 8'hFF);
        link.deliver(9'h0C0, 1'b0, 1'b0);
        rchk("ctrl2", OFF_CTRL2, 8'h24, 8'hFF);
        clear_rx();
        wr(OFF_CTRL1, 8'h00);
        wr(OFF_CTRL2, 8'h26);
        link.idle();
        rchk("ctrl2", OFF_CTRL2, 8'h24, 8'hFF);
        rchk("status", OFF_STATUS, 8'h00, 8'h3F);
        link.idle();
        rchk("status", OFF_STATUS, 8'h10, 8'h3F);
        rd(OFF_DATA);
        link.idle();
        rchk("status", OFF_STATUS, 8'h00, 8'h3F);
        link.deliver(9'h055, 1'b0, 1'b0);
        clear_rx();
        link.idle();
        rchk("status", OFF_STATUS, 8'h10, 8'h3F);
        clear_rx();
        // Both shifters are quiet here, so power-down stops the block at once
        wr(OFF_CTRL1, 8'h20);
        repeat (2) @(posedge aclk);
        chk("run", 9'h000, {8'h00, serial_run});
        wr(OFF_CTRL1, 8'h00);
        repeat (2) @(posedge aclk);
        chk("run", 9'h001, {8'h00, serial_run});
        halt_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("run", 9'h000, {8'h00, serial_run});
        link.deliver(9'h055, 1'b0, 1'b0);
        rchk("status", OFF_STATUS, 8'h00, 8'h3F);
        complete_run();
    end
endmodule : umps_core_bench
`default_nettype wire
